// ### logic/wer_routing.sv
// Wake-up event routing enables: APB registers, detector gating and interrupt routing
//
// Notes on behaviour
// - Standby power-up or software reset clears the interrupt-routing register to zero.
// - A set routing bit raises the interrupt for its detected event, regardless of wake enables; the code also needs the event's irq_mask bit set.
// - Interrupt-routing register for general-purpose events sits at index 16h.
// - Routing bit n serves general-purpose event n; bit 4 is the shared ring event.
// - With main supply present, raw events reach detectors only when enabled.
// - First supply-present register: index 17h, reset 1Fh, bits 7-5 reserved.
// - Second supply-present register resets to FFh; bit n gates general-purpose event n.
// - Second supply-present register sits at index 18h.
// - With main supply absent, raw non-general events reach detectors only when enabled.
// - Supply-absent register: index 19h, reset 1Fh, same layout, bits 7-5 reserved.
//
// The implementer's own choice: register access over APB.
`include "wer_consts.svh"
`default_nettype none

module wer_routing (
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Main supply sense pin
    input wire logic vdd_present,
    // Raw wake-up events from pins
    input wire wer_pkg::wer_events_t raw_events,
    // Supply-absent gate for general-purpose events, kept by a neighbouring register
    input wire logic [7:0] off_gp_enable,
    // Gated events toward the event detectors
    output wer_pkg::wer_events_t detector_events,
    // Detected general-purpose events back from the detectors (same clock)
    input wire logic [7:0] detected_gp_events,
    // Interrupt channel request
    output logic irq
);

    // ======================================================================
    // Registers and decode
    // ======================================================================
    logic [7:0] gp_event_irq_route_enable;
    logic [7:0] vdd_on_detector_enable_a;
    logic [7:0] vdd_on_detector_enable_b;
    logic [7:0] vdd_off_detector_enable_a;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic soft_reset;

    logic [5:0] reg_index;
    logic addr_aligned;
    logic addr_mapped;
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic [7:0] wdata;
    logic [31:0] next_prdata;

    assign reg_index = paddr[7:2];
    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wdata = pwdata[7:0];

    always_comb
    begin
        unique case (reg_index)
            `WER_IDX_IRQ_ROUTE, `WER_IDX_ON_EN_A, `WER_IDX_ON_EN_B, `WER_IDX_OFF_EN_A,
            `WER_IDX_IRQ_STATUS, `WER_IDX_IRQ_MASK, `WER_IDX_SOFT_RESET:
                addr_mapped = addr_aligned;
            default:
                addr_mapped = 1'b0;
        endcase
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access_phase && !addr_mapped;
    assign wr_access = access_phase && pwrite && addr_mapped;

    // ======================================================================
    // Software reset pulse
    // ======================================================================
    // Registered so the pulse lands one cycle after the write, like a reset would
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_reset <= 1'b0;
        end
        else
        begin
            soft_reset <= wr_access && (reg_index == `WER_IDX_SOFT_RESET) && wdata[`WER_BIT_SOFT_RESET];
        end
    end

    // ======================================================================
    // Enable registers
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gp_event_irq_route_enable <= `WER_RST_IRQ_ROUTE;
        end
        else if (soft_reset)
        begin
            gp_event_irq_route_enable <= `WER_RST_IRQ_ROUTE;
        end
        else if (wr_access && reg_index == `WER_IDX_IRQ_ROUTE)
        begin
            gp_event_irq_route_enable <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vdd_on_detector_enable_a <= `WER_RST_ON_EN_A;
        end
        else if (soft_reset)
        begin
            vdd_on_detector_enable_a <= `WER_RST_ON_EN_A;
        end
        else if (wr_access && reg_index == `WER_IDX_ON_EN_A)
        begin
            vdd_on_detector_enable_a <= wdata & `WER_MASK_EXT_A;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vdd_on_detector_enable_b <= `WER_RST_ON_EN_B;
        end
        else if (soft_reset)
        begin
            vdd_on_detector_enable_b <= `WER_RST_ON_EN_B;
        end
        else if (wr_access && reg_index == `WER_IDX_ON_EN_B)
        begin
            vdd_on_detector_enable_b <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vdd_off_detector_enable_a <= `WER_RST_OFF_EN_A;
        end
        else if (soft_reset)
        begin
            vdd_off_detector_enable_a <= `WER_RST_OFF_EN_A;
        end
        else if (wr_access && reg_index == `WER_IDX_OFF_EN_A)
        begin
            vdd_off_detector_enable_a <= wdata & `WER_MASK_EXT_A;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask <= `WER_RST_IRQ_MASK;
        end
        else if (soft_reset)
        begin
            irq_mask <= `WER_RST_IRQ_MASK;
        end
        else if (wr_access && reg_index == `WER_IDX_IRQ_MASK)
        begin
            irq_mask <= wdata;
        end
    end

    // ======================================================================
    // Read data, captured in the setup cycle
    // ======================================================================
    always_comb
    begin
        next_prdata = `WER_ZERO_WORD;
        unique case (reg_index)
            `WER_IDX_IRQ_ROUTE: next_prdata[7:0] = gp_event_irq_route_enable;
            `WER_IDX_ON_EN_A: next_prdata[7:0] = vdd_on_detector_enable_a;
            `WER_IDX_ON_EN_B: next_prdata[7:0] = vdd_on_detector_enable_b;
            `WER_IDX_OFF_EN_A: next_prdata[7:0] = vdd_off_detector_enable_a;
            `WER_IDX_IRQ_STATUS: next_prdata[7:0] = irq_status;
            `WER_IDX_IRQ_MASK: next_prdata[7:0] = irq_mask;
            default: next_prdata = `WER_ZERO_WORD;
        endcase
        if (!addr_aligned)
        begin
            next_prdata = `WER_ZERO_WORD;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= `WER_ZERO_WORD;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata <= next_prdata;
        end
    end

    // ======================================================================
    // Raw event gating toward the detectors
    // ======================================================================
    wer_pkg::wer_events_t raw_sync;
    logic vdd_present_sync;
    wer_pkg::wer_events_t next_detector_events;

    wer_sync #(
        .WIDTH($bits(wer_pkg::wer_events_t) + 1)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({raw_events, vdd_present}),
        .sync_out({raw_sync, vdd_present_sync})
    );

    always_comb
    begin
        if (vdd_present_sync)
        begin
            next_detector_events.ext = raw_sync.ext & vdd_on_detector_enable_a[4:0];
            next_detector_events.gp_input_event = raw_sync.gp_input_event & vdd_on_detector_enable_b;
        end
        else
        begin
            next_detector_events.ext = raw_sync.ext & vdd_off_detector_enable_a[4:0];
            // General-purpose events use the neighbouring supply-absent register
            next_detector_events.gp_input_event = raw_sync.gp_input_event & off_gp_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            detector_events <= '0;
        end
        else
        begin
            detector_events <= next_detector_events;
        end
    end

    // ======================================================================
    // Interrupt routing of detected general-purpose events
    // ======================================================================
    logic [7:0] routed_events;
    logic [7:0] status_clear;

    // The general wake enables play no part here
    assign routed_events = detected_gp_events & gp_event_irq_route_enable;
    assign status_clear = (wr_access && reg_index == `WER_IDX_IRQ_STATUS) ? wdata : `WER_RST_STATUS;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= `WER_RST_STATUS;
        end
        else if (soft_reset)
        begin
            irq_status <= `WER_RST_STATUS;
        end
        else
        begin
            irq_status <= (irq_status & ~status_clear) | routed_events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ======================================================================
    // Checks
    // ======================================================================
    route_soft_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        soft_reset |=> (gp_event_irq_route_enable == `WER_RST_IRQ_ROUTE)
    ) else $error("Routing register not cleared by software reset");

    route_raises_irq_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (detected_gp_events[`WER_BIT_RING_SHARED] && gp_event_irq_route_enable[`WER_BIT_RING_SHARED]
            && irq_mask[`WER_BIT_RING_SHARED] && !soft_reset) ##1 irq_mask[`WER_BIT_RING_SHARED] |-> irq
    ) else $error("Routed shared ring event did not raise the interrupt");

    route_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == {`WER_IDX_IRQ_ROUTE, 2'b00} && !soft_reset)
            |=> (gp_event_irq_route_enable == $past(pwdata[7:0]))
    ) else $error("Write to routing register not taken");

    route_bit_map_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!soft_reset && !(wr_access && reg_index == `WER_IDX_IRQ_STATUS))
            |=> ((irq_status & ~$past(irq_status)) == ($past(routed_events) & ~$past(irq_status)))
    ) else $error("Status bit set without its routed event");

    on_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        vdd_present_sync |=> (detector_events.ext == ($past(raw_sync.ext) & $past(vdd_on_detector_enable_a[4:0])))
    ) else $error("Supply-present gating wrong for extension events");

    on_a_reserved_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        vdd_on_detector_enable_a[7:5] == 3'b000
    ) else $error("Reserved bits of first supply-present register set");

    on_b_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        vdd_present_sync ##1 1'b1 |-> detector_events.gp_input_event
            == ($past(raw_sync.gp_input_event) & $past(vdd_on_detector_enable_b))
    ) else $error("Supply-present gating wrong for general-purpose events");

    on_b_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == {`WER_IDX_ON_EN_B, 2'b00} && !soft_reset)
            |=> (vdd_on_detector_enable_b == $past(pwdata[7:0]))
    ) else $error("Write to second supply-present register not taken");

    off_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !vdd_present_sync |=> (detector_events.ext == ($past(raw_sync.ext) & $past(vdd_off_detector_enable_a[4:0])))
    ) else $error("Supply-absent gating wrong");

    off_soft_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        soft_reset |=> (vdd_off_detector_enable_a == `WER_RST_OFF_EN_A && vdd_on_detector_enable_a == `WER_RST_ON_EN_A)
    ) else $error("Extension registers not restored to 1Fh");

    // Compare with the setup-cycle value: a software reset may land between setup and access
    off_readback_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == {`WER_IDX_OFF_EN_A, 2'b00}) ##1 access_phase
            |-> (prdata == {24'h00_0000, $past(vdd_off_detector_enable_a)})
    ) else $error("Read data does not match supply-absent register");

endmodule : wer_routing

`default_nettype wire

// ### logic/wer_consts.svh
// Register indices, reset values and field layout of the wake-up routing enables
`ifndef WER_CONSTS_SVH
`define WER_CONSTS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define WER_IDX_IRQ_ROUTE 6'h16
`define WER_IDX_ON_EN_A 6'h17
`define WER_IDX_ON_EN_B 6'h18
`define WER_IDX_OFF_EN_A 6'h19
`define WER_IDX_IRQ_STATUS 6'h1D
`define WER_IDX_IRQ_MASK 6'h1E
`define WER_IDX_SOFT_RESET 6'h1F

// ==========================================================================
// Reset values and masks
// ==========================================================================
`define WER_RST_IRQ_ROUTE 8'h00
`define WER_RST_ON_EN_A 8'h1F
`define WER_RST_ON_EN_B 8'hFF
`define WER_RST_OFF_EN_A 8'h1F
`define WER_RST_IRQ_MASK 8'hFF
`define WER_RST_STATUS 8'h00
`define WER_MASK_EXT_A 8'h1F
`define WER_ZERO_WORD 32'h0000_0000

// ==========================================================================
// Field positions
// ==========================================================================
`define WER_BIT_SOFT_RESET 0
`define WER_BIT_RING_SHARED 4
`define WER_BIT_INFRARED 4
`define WER_BIT_MOUSE 3
`define WER_BIT_KEYBOARD 2
`define WER_BIT_RING_TWO 1
`define WER_BIT_RING_ONE 0

`endif

// ### logic/wer_pkg.sv
// Types shared by the wake-up routing enable block
`default_nettype none

package wer_pkg;

    // Raw or gated wake-up events, grouped as the enable registers are
    typedef struct packed {
        logic infrared_remote_event;
        logic mouse;
        logic keyboard;
        logic ring_indicate_two;
        logic ring_indicate_one;
    } wer_ext_events_t;

    typedef struct packed {
        wer_ext_events_t ext;
        logic [7:0] gp_input_event;
    } wer_events_t;

endpackage : wer_pkg

`default_nettype wire

// ### logic/wer_sync.sv
// Two-stage synchroniser, one per bit
`default_nettype none

module wer_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    genvar i;

    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic stage_one;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    stage_one <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    stage_one <= async_in[i];
                    sync_out[i] <= stage_one;
                end
            end
        end
    endgenerate

endmodule : wer_sync

`default_nettype wire

// ### verif/tb_top.sv
// Self-checking testbench for the wake-up routing enable block
`include "wer_consts.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vdd_present;
    wer_pkg::wer_events_t raw_events;
    logic [7:0] off_gp_enable;
    wer_pkg::wer_events_t detector_events;
    logic [7:0] detected_gp_events;
    logic irq;
    int n_fail;
    int n_compared;
    logic [31:0] rd;
    logic err;
    logic [7:0] d;
    logic [7:0] det;
    logic [7:0] route;
    logic [7:0] m;
    logic [7:0] shadow [4];
    logic [5:0] idx [4] = '{`WER_IDX_IRQ_ROUTE, `WER_IDX_ON_EN_A, `WER_IDX_ON_EN_B, `WER_IDX_OFF_EN_A};
    logic [7:0] rstv [4] = '{`WER_RST_IRQ_ROUTE, `WER_RST_ON_EN_A, `WER_RST_ON_EN_B, `WER_RST_OFF_EN_A};
    // Writable bits; reserved ones must read back zero
    logic [7:0] keep [4] = '{8'hFF, `WER_MASK_EXT_A, 8'hFF, `WER_MASK_EXT_A};

    wer_routing dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .vdd_present(vdd_present),
        .raw_events(raw_events),
        .off_gp_enable(off_gp_enable),
        .detector_events(detector_events),
        .detected_gp_events(detected_gp_events),
        .irq(irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ======================================================================
    // Tasks and expectations
    // ======================================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // Setup cycle, then access until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait that never gets an answer
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
    endtask : apb

    function automatic logic [12:0] exp_det(logic vdd, logic [12:0] raw, logic [7:0] on_a, logic [7:0] on_b,
                                            logic [7:0] off_a, logic [7:0] off_gp);
        if (vdd)
            return raw & {on_a[4:0], on_b};
        return raw & {off_a[4:0], off_gp};
    endfunction : exp_det

    task automatic check_resets();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, {idx[i], 2'b00}, 8'h00);
            chk(rd, {24'h00_0000, rstv[i]});
            chk({31'h0, err}, 32'h0000_0000);
            shadow[i] = rstv[i];
        end
    endtask : check_resets

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial
    begin
        n_fail = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        vdd_present = 1'b1;
        raw_events = '0;
        off_gp_enable = 8'h00;
        detected_gp_events = 8'h00;
        rd = $urandom(32'h0000_3bc9);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check_resets();
        // Readback, reserved bits set on the first pass
        for (int k = 0; k < 16; k++)
        begin
            d = (k < 4) ? 8'hFF : 8'($urandom);
            apb(1'b1, {idx[k % 4], 2'b00}, d);
            apb(1'b0, {idx[k % 4], 2'b00}, 8'h00);
            chk(rd, {24'h00_0000, d & keep[k % 4]});
            shadow[k % 4] = d & keep[k % 4];
        end
        // Unmapped and unaligned accesses are refused and leave the map alone
        apb(1'b1, 8'h59, 8'hA5);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 8'h00, 8'h00);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b0, {idx[0], 2'b00}, 8'h00);
        chk(rd, {24'h00_0000, shadow[0]});
        // Detector gating in both supply states
        for (int k = 0; k < 16; k++)
        begin
            for (int i = 1; i < 4; i++)
            begin
                d = (k == 0) ? 8'h00 : 8'($urandom);
                apb(1'b1, {idx[i], 2'b00}, d);
                shadow[i] = d & keep[i];
            end
            @(posedge pclk);
            vdd_present <= k[0];
            raw_events <= wer_pkg::wer_events_t'(13'($urandom));
            off_gp_enable <= 8'($urandom);
            repeat (6) @(posedge pclk);
            @(negedge pclk);
            chk({19'h0, detector_events}, {19'h0, exp_det(vdd_present, raw_events, shadow[1], shadow[2],
                shadow[3], off_gp_enable)});
        end
        // Routing of detected events to the interrupt, mask and clear
        for (int n = 0; n < 8; n++)
        begin
            route = (n == 0) ? 8'h00 : 8'($urandom);
            det = (n == 0) ? 8'hFF : (8'($urandom) | (8'h01 << n));
            apb(1'b1, {idx[0], 2'b00}, route);
            @(posedge pclk);
            detected_gp_events <= det;
            @(posedge pclk);
            detected_gp_events <= 8'h00;
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk({31'h0, irq}, {31'h0, |(det & route)});
            apb(1'b0, {`WER_IDX_IRQ_STATUS, 2'b00}, 8'h00);
            chk(rd, {24'h00_0000, det & route});
            m = 8'($urandom);
            apb(1'b1, {`WER_IDX_IRQ_MASK, 2'b00}, m);
            @(negedge pclk);
            chk({31'h0, irq}, {31'h0, |(det & route & m)});
            apb(1'b1, {`WER_IDX_IRQ_MASK, 2'b00}, 8'hFF);
            apb(1'b1, {`WER_IDX_IRQ_STATUS, 2'b00}, 8'hFF);
            @(negedge pclk);
            chk({31'h0, irq}, 32'h0000_0000);
        end
        // Software reset, then a second power-up reset in mid-run
        for (int kind = 0; kind < 2; kind++)
        begin
            for (int i = 0; i < 4; i++)
                apb(1'b1, {idx[i], 2'b00}, ~rstv[i]);
            if (kind == 0)
            begin
                apb(1'b1, {`WER_IDX_SOFT_RESET, 2'b00}, 8'h01);
                repeat (2) @(posedge pclk);
            end
            else
            begin
                @(posedge pclk);
                presetn <= 1'b0;
                repeat (2) @(posedge pclk);
                @(negedge pclk);
                chk({30'h0, irq, pready}, 32'h0000_0001);
                chk({19'h0, detector_events}, 32'h0000_0000);
                @(posedge pclk);
                presetn <= 1'b1;
            end
            check_resets();
        end
        print_verdict();
    end

    // Whole run is about six hundred cycles; this leaves ample margin
    initial
    begin
        #200_000;
        n_fail++;
        print_verdict();
    end

endmodule : tb_top

`default_nettype wire
